// >>> design/imc_ctrl.sv
// Register bank for analog input routing and calibration engine control.
// Assumes same-clock control inputs from the link and calibration logic.
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - Dual mode: swap bit crosses input routing
// R2 - Swap ignored in single-channel link formats
// R3 - Single select: 1 input A, 2 input B
// R4 - Single select 3: channel A/A, channel B/B
// R5 - Single select ignored in dual-channel formats
// R6 - Mux change applies only when calibration runs
// R7 - Run enable low holds calibration in reset
// R8 - Run enable low resets processing clock dividers
// R9 - Software clears run enable before calibration edits
// R10 - Software sets run enable before link enable
// R11 - Software clears link enable before run enable
// R12 - Background offset needs background calibration enabled
// R13 - Foreground offset needs foreground calibration selected
// R14 - Background enable bit turns on background calibration
// R15 - Calibration clears values, then optional foreground
// R16 - Idle-core select picks disabled core, substitution
// R17 - Software changes idle core only link disabled
// R18 - Reserved bits read back, no effect
module imc_ctrl (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       link_format_single_in,
  input  wire logic       serial_link_enable_in,
  input  wire logic       fg_cal_done_in,
  output logic            cal_run_out,
  output logic            cal_values_clear_out,
  output logic            fg_cal_active_out,
  output logic            fg_offset_active_out,
  output logic            bg_cal_active_out,
  output logic            bg_offset_active_out,
  output logic            fg_done_out,
  output logic            divider_reset_out,
  output logic            chan_a_src_out,
  output logic            chan_b_src_out,
  output logic            core_idle_en_out,
  output logic      [1:0] core_idle_sel_out,
  output logic            core1_substitute_out,
  output logic      [2:0] lin_avg_out,
  output logic      [2:0] os_avg_out
);
  import imc_pkg::*;

  // ----------------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------------
  logic [7:0]     input_route_select;
  logic [7:0]     calibration_run_control;
  logic [7:0]     calibration_mode_config;
  logic [7:0]     idle_core_config;
  logic [7:0]     calibration_averaging;

  imc_cal_state_t cal_state;
  imc_cal_state_t next_cal_state;
  logic           fg_done;
  logic           applied_swap;
  logic [1:0]     applied_single_sel;
  logic [1:0]     applied_idle_core;

  imc_route_if route ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_route = (reg_addr_in == OFF_INPUT_ROUTE_SELECT);
  wire hit_run   = (reg_addr_in == OFF_CALIBRATION_RUN_CTRL);
  wire hit_mode  = (reg_addr_in == OFF_CALIBRATION_MODE_CFG);
  wire hit_idle  = (reg_addr_in == OFF_IDLE_CORE_CONFIG);
  wire hit_avg   = (reg_addr_in == OFF_CALIBRATION_AVERAGING);
  wire hit_stat  = (reg_addr_in == OFF_CALIBRATION_STATE_STAT);

  wire run_enable = calibration_run_control[POS_RUN_ENABLE];
  wire fg_select  = calibration_mode_config[POS_FG_SELECT];
  wire bg_enable  = calibration_mode_config[POS_BG_ENABLE];
  wire fg_offset  = calibration_mode_config[POS_FG_OFFSET];
  wire bg_offset  = calibration_mode_config[POS_BG_OFFSET];

  wire [7:0] status_word = {serial_link_enable_in, route.route_valid, applied_swap,
                            applied_single_sel, fg_done, cal_state};

  logic [7:0] read_mux;
  always_comb begin
    if (hit_route) begin
      read_mux = input_route_select;
    end else if (hit_run) begin
      read_mux = calibration_run_control;
    end else if (hit_mode) begin
      read_mux = calibration_mode_config;
    end else if (hit_idle) begin
      read_mux = idle_core_config;
    end else if (hit_avg) begin
      read_mux = calibration_averaging;
    end else if (hit_stat) begin
      read_mux = status_word;
    end else begin
      read_mux = RST_READ_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Full bytes are stored so reserved bits read back (see R18)
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      input_route_select      <= RST_INPUT_ROUTE_SELECT;
      calibration_run_control <= RST_CALIBRATION_RUN_CTRL;
      calibration_mode_config <= RST_CALIBRATION_MODE_CFG;
      idle_core_config        <= RST_IDLE_CORE_CONFIG;
      calibration_averaging   <= RST_CALIBRATION_AVERAGING;
    end else if (reg_wr_in) begin
      if (hit_route) input_route_select <= reg_wdata_in;
      if (hit_run)   calibration_run_control <= reg_wdata_in;
      if (hit_mode)  calibration_mode_config <= reg_wdata_in;
      if (hit_idle)  idle_core_config <= reg_wdata_in;
      if (hit_avg)   calibration_averaging <= reg_wdata_in;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= RST_READ_DATA;
    end else begin
      reg_rdata_out <= reg_rd_in ? read_mux : RST_READ_DATA;
    end
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  // Held while run enable is low (see R7); a run clears values first
  // and then runs or skips foreground (see R15)
  always_comb begin
    next_cal_state = cal_state;
    case (cal_state)
      CAL_HELD: begin
        if (run_enable) next_cal_state = CAL_CLEAR;
      end
      CAL_CLEAR: begin
        next_cal_state = fg_select ? CAL_FORE : CAL_RUNNING;
      end
      CAL_FORE: begin
        if (fg_cal_done_in) next_cal_state = CAL_RUNNING;
      end
      default: begin
        next_cal_state = CAL_RUNNING;
      end
    endcase
    if (!run_enable) next_cal_state = CAL_HELD;
  end

  wire fg_finished = (cal_state == CAL_FORE && fg_cal_done_in) ||
                     (cal_state == CAL_CLEAR && !fg_select);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cal_state <= CAL_HELD;
      fg_done   <= 1'b0;
    end else begin
      cal_state <= next_cal_state;
      if (!run_enable || cal_state == CAL_HELD) begin
        fg_done <= 1'b0;
      end else if (fg_finished) begin
        fg_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Applied route and idle core
  // ----------------------------------------------------------------
  // Taken only as a calibration begins, so a mux edit waits for a run
  // and only a link format change moves the channels mid-calibration (see R6)
  wire capture = (cal_state == CAL_CLEAR);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      applied_swap       <= RST_INPUT_ROUTE_SELECT[POS_DUAL_SWAP];
      applied_single_sel <= RST_INPUT_ROUTE_SELECT[POS_SINGLE_SEL_LO +: 2];
      applied_idle_core  <= RST_IDLE_CORE_CONFIG[POS_IDLE_CORE_LO +: 2];
    end else if (capture) begin
      applied_swap       <= input_route_select[POS_DUAL_SWAP];
      applied_single_sel <= input_route_select[POS_SINGLE_SEL_LO +: 2];
      applied_idle_core  <= idle_core_config[POS_IDLE_CORE_LO +: 2];
    end
  end

  assign route.single_mode = link_format_single_in;
  assign route.dual_swap   = applied_swap;
  assign route.single_sel  = applied_single_sel;

  imc_route_dec u_route_dec (
    .route (route)
  );

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  wire running = (cal_state == CAL_RUNNING);
  wire fore    = (cal_state == CAL_FORE);

  // Idle core only applies without background calibration (see R16)
  wire idle_valid = (applied_idle_core != CORE_RESERVED) && !bg_enable;

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cal_run_out          <= 1'b0;
      cal_values_clear_out <= 1'b0;
      fg_cal_active_out    <= 1'b0;
      fg_offset_active_out <= 1'b0;
      bg_cal_active_out    <= 1'b0;
      bg_offset_active_out <= 1'b0;
      fg_done_out          <= 1'b0;
      divider_reset_out    <= 1'b1;
      chan_a_src_out       <= SRC_INPUT_A;
      chan_b_src_out       <= SRC_INPUT_B;
      core_idle_en_out     <= 1'b0;
      core_idle_sel_out    <= RST_IDLE_CORE_CONFIG[POS_IDLE_CORE_LO +: 2];
      core1_substitute_out <= 1'b0;
      lin_avg_out          <= RST_CALIBRATION_AVERAGING[POS_LIN_AVG_LO +: 3];
      os_avg_out           <= RST_CALIBRATION_AVERAGING[POS_OS_AVG_LO +: 3];
    end else begin
      cal_run_out          <= run_enable;                        // see R7
      cal_values_clear_out <= capture;                           // see R15
      fg_cal_active_out    <= fore;                              // see R15
      fg_offset_active_out <= fore && fg_select && fg_offset;    // see R13
      bg_cal_active_out    <= running && bg_enable;              // see R14
      bg_offset_active_out <= running && bg_enable && bg_offset; // see R12
      fg_done_out          <= fg_done;
      divider_reset_out    <= !run_enable;                       // see R8
      // Reserved single select keeps the previous route
      if (route.route_valid) begin
        chan_a_src_out <= route.chan_a_src;                      // see R1
        chan_b_src_out <= route.chan_b_src;                      // see R4
      end
      core_idle_en_out     <= idle_valid;                        // see R16
      core_idle_sel_out    <= applied_idle_core;
      core1_substitute_out <= idle_valid && (applied_idle_core != 2'h1);
      lin_avg_out          <= calibration_averaging[POS_LIN_AVG_LO +: 3];
      os_avg_out           <= calibration_averaging[POS_OS_AVG_LO +: 3];
    end
  end

endmodule

// >>> design/imc_pkg.sv
// Constants and types shared by the input-route and calibration control bank.
// Assumes one 250 MHz clock and an 8-bit register port with byte offsets.
package imc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INPUT_ROUTE_SELECT     = 8'h60;
  localparam logic [7:0] OFF_CALIBRATION_RUN_CTRL   = 8'h61;
  localparam logic [7:0] OFF_CALIBRATION_MODE_CFG   = 8'h62;
  localparam logic [7:0] OFF_IDLE_CORE_CONFIG       = 8'h64;
  localparam logic [7:0] OFF_CALIBRATION_AVERAGING  = 8'h68;
  localparam logic [7:0] OFF_CALIBRATION_STATE_STAT = 8'h70;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INPUT_ROUTE_SELECT    = 8'h01;
  localparam logic [7:0] RST_CALIBRATION_RUN_CTRL  = 8'h01;
  localparam logic [7:0] RST_CALIBRATION_MODE_CFG  = 8'h01;
  localparam logic [7:0] RST_IDLE_CORE_CONFIG      = 8'h02;
  localparam logic [7:0] RST_CALIBRATION_AVERAGING = 8'h61;
  localparam logic [7:0] RST_READ_DATA             = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POS_SINGLE_SEL_LO = 0;
  localparam int unsigned POS_DUAL_SWAP     = 4;
  localparam int unsigned POS_RUN_ENABLE    = 0;
  localparam int unsigned POS_FG_SELECT     = 0;
  localparam int unsigned POS_BG_ENABLE     = 1;
  localparam int unsigned POS_FG_OFFSET     = 2;
  localparam int unsigned POS_BG_OFFSET     = 3;
  localparam int unsigned POS_IDLE_CORE_LO  = 0;
  localparam int unsigned POS_LIN_AVG_LO    = 0;
  localparam int unsigned POS_OS_AVG_LO     = 4;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_RESERVED  = 2'h0;
  localparam logic [1:0] SEL_INPUT_A   = 2'h1;
  localparam logic [1:0] SEL_INPUT_B   = 2'h2;
  localparam logic [1:0] SEL_DUAL_DES  = 2'h3;
  localparam logic [1:0] CORE_RESERVED = 2'h3;
  localparam logic       SRC_INPUT_A   = 1'b0;
  localparam logic       SRC_INPUT_B   = 1'b1;

  typedef enum logic [1:0] {
    CAL_HELD    = 2'b00,
    CAL_CLEAR   = 2'b01,
    CAL_FORE    = 2'b10,
    CAL_RUNNING = 2'b11
  } imc_cal_state_t;

endpackage

// >>> design/imc_route_dec.sv
// Decodes the applied input-route fields into a source for each channel.
// Assumes swap and select are stable copies taken when calibration starts; single_mode is live.
module imc_route_dec (
  imc_route_if.dec route
);
  import imc_pkg::*;

  wire sel_a    = (route.single_sel == SEL_INPUT_A);
  wire sel_b    = (route.single_sel == SEL_INPUT_B);
  wire sel_des  = (route.single_sel == SEL_DUAL_DES);

  // Swap only matters in dual-channel formats (see R1) (see R2)
  wire dual_a   = route.dual_swap ? SRC_INPUT_B : SRC_INPUT_A;
  wire dual_b   = route.dual_swap ? SRC_INPUT_A : SRC_INPUT_B;

  // Single select only matters in single-channel formats (see R3) (see R5)
  // Value 3 splits the cores across both inputs (see R4)
  wire single_a = sel_b ? SRC_INPUT_B : SRC_INPUT_A;
  wire single_b = (sel_b | sel_des) ? SRC_INPUT_B : SRC_INPUT_A;

  assign route.chan_a_src  = route.single_mode ? single_a : dual_a;
  assign route.chan_b_src  = route.single_mode ? single_b : dual_b;
  // Reserved select value yields no valid route in single-channel formats
  assign route.route_valid = !route.single_mode | sel_a | sel_b | sel_des;

endmodule

// >>> design/imc_route_if.sv
// Carries the applied route setting to the route decoder and its result back.
// Assumes both ends sit on the same clock.
interface imc_route_if;
  logic       single_mode;
  logic       dual_swap;
  logic [1:0] single_sel;
  logic       chan_a_src;
  logic       chan_b_src;
  logic       route_valid;

  modport ctrl (output single_mode, output dual_swap, output single_sel,
                input chan_a_src, input chan_b_src, input route_valid);
  modport dec  (input single_mode, input dual_swap, input single_sel,
                output chan_a_src, output chan_b_src, output route_valid);
endinterface

// >>> verif/imc_ctrl_properties.sv
// Concurrent checks on the route and calibration control bank ports.
// Bound to every imc_ctrl instance; sees only that module's ports.
module imc_ctrl_properties
  import imc_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       fg_cal_done_in,
  input wire logic       cal_run_out,
  input wire logic       cal_values_clear_out,
  input wire logic       fg_cal_active_out,
  input wire logic       fg_offset_active_out,
  input wire logic       bg_cal_active_out,
  input wire logic       bg_offset_active_out,
  input wire logic       fg_done_out,
  input wire logic       divider_reset_out,
  input wire logic       core_idle_en_out,
  input wire logic [1:0] core_idle_sel_out,
  input wire logic       core1_substitute_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  wire logic addr_mapped;
  assign addr_mapped = reg_addr_in inside {OFF_INPUT_ROUTE_SELECT, OFF_CALIBRATION_RUN_CTRL,
                       OFF_CALIBRATION_MODE_CFG, OFF_IDLE_CORE_CONFIG, OFF_CALIBRATION_AVERAGING};
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  a_write_read: assert property (reg_wr_in && addr_mapped ##1 reg_rd_in && reg_addr_in == $past(reg_addr_in)
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("register did not read back written value");
  a_run_low: assert property (reg_wr_in && reg_addr_in == OFF_CALIBRATION_RUN_CTRL && !reg_wdata_in[0]
    |-> ##2 divider_reset_out && !cal_run_out) else $error("run enable low did not hold calibration");
  a_run_high: assert property (reg_wr_in && reg_addr_in == OFF_CALIBRATION_RUN_CTRL && reg_wdata_in[0]
    |-> ##2 cal_run_out && !divider_reset_out) else $error("run enable high did not release calibration");
  a_clear_pulse: assert property (cal_values_clear_out |=> !cal_values_clear_out)
    else $error("value clear pulse longer than one cycle");
  a_clear_after_run: assert property ($rose(cal_run_out) |-> ##[1:2] cal_values_clear_out)
    else $error("calibration start did not clear values");
  a_fg_offset: assert property (fg_offset_active_out |-> fg_cal_active_out)
    else $error("foreground offset active without foreground calibration");
  a_bg_offset: assert property (bg_offset_active_out |-> bg_cal_active_out)
    else $error("background offset active without background calibration");
  a_idle_core: assert property (core_idle_en_out |-> core_idle_sel_out != CORE_RESERVED && !bg_cal_active_out)
    else $error("core idled with reserved code or background calibration");
  a_core1_sub: assert property (core1_substitute_out == (core_idle_en_out && core_idle_sel_out != 2'h1))
    else $error("core 1 substitution mismatch");
  a_fg_done: assert property (fg_cal_active_out && fg_cal_done_in |-> ##[1:2] fg_done_out)
    else $error("foreground done not flagged");
endmodule

bind imc_ctrl imc_ctrl_properties u_props (.*);

// >>> verif/imc_ctrl_tb_top.sv
// Self-checking bench for the route and calibration control bank.
// Drives the register port and the calibration engine inputs directly.
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module imc_ctrl_tb_top
  import imc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus and checking
  // ----------------------------------------------------------------
  typedef struct {string nm; logic [7:0] e;} imc_note_t;
  imc_note_t  notes[$];
  logic       sys_clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_d = 1'b0;
  logic       link_format_single_in = 1'b0, serial_link_enable_in = 1'b0, fg_cal_done_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, d;
  logic       cal_run_out, cal_values_clear_out, fg_cal_active_out, fg_offset_active_out, bg_cal_active_out;
  logic       bg_offset_active_out, fg_done_out, divider_reset_out, chan_a_src_out, chan_b_src_out;
  logic       core_idle_en_out, core1_substitute_out;
  logic [1:0] core_idle_sel_out;
  logic [2:0] lin_avg_out, os_avg_out;
  logic [7:0] offs[5] = '{8'h60, 8'h61, 8'h62, 8'h64, 8'h68};
  // Route cases: single mode, route register, expected channel A and B sources
  logic [10:0] rt[6] = '{{1'b0, 8'h01, 2'b01}, {1'b0, 8'h10, 2'b10}, {1'b0, 8'h12, 2'b10},
                         {1'b1, 8'h11, 2'b00}, {1'b1, 8'h12, 2'b11}, {1'b1, 8'h13, 2'b01}};
  int         error_cnt = 0, checks = 0, seed = 32'hde7c;

  imc_ctrl dut (.*);

  initial forever #2 sys_clk_in = ~sys_clk_in;

  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_in);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= v;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    notes.push_back('{nm, e});
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  // Read answers stand only in the cycle after the strobe
  always @(posedge sys_clk_in) rd_d <= reg_rd_in;
  always @(negedge sys_clk_in) begin
    if (rd_d && notes.size() > 0) begin
      `CHK(notes[0].nm, notes[0].e, reg_rdata_out)
      void'(notes.pop_front());
    end
  end

  // Full recalibration with new route, mode and idle core, then port checks
  task automatic rerun(input logic s, input logic [7:0] r, input logic [7:0] cf, input logic [7:0] il,
                       input logic ea, input logic eb);
    int n = 0;
    @(posedge sys_clk_in);
    serial_link_enable_in <= 1'b0;
    link_format_single_in <= s;
    bus(1'b1, 1'b0, OFF_CALIBRATION_RUN_CTRL, 8'h00);
    bus(1'b1, 1'b0, OFF_INPUT_ROUTE_SELECT, r);
    bus(1'b1, 1'b0, OFF_CALIBRATION_MODE_CFG, cf);
    bus(1'b1, 1'b0, OFF_IDLE_CORE_CONFIG, il);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge sys_clk_in);
    `CHK("divider_reset", 1'b1, divider_reset_out)
    `CHK("cal_run", 1'b0, cal_run_out)
    bus(1'b1, 1'b0, OFF_CALIBRATION_RUN_CTRL, 8'h01);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    while (cf[0] && fg_cal_active_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (cf[0]) begin
      `CHK("fg_active", 1'b1, fg_cal_active_out)
      `CHK("fg_offset", cf[2], fg_offset_active_out)
      @(posedge sys_clk_in) fg_cal_done_in <= 1'b1;
      @(posedge sys_clk_in) fg_cal_done_in <= 1'b0;
    end
    repeat (4) @(negedge sys_clk_in);
    `CHK("fg_done", 1'b1, fg_done_out)
    `CHK("fg_idle", 1'b0, fg_cal_active_out)
    `CHK("bg_cal", cf[1], bg_cal_active_out)
    `CHK("bg_offset", cf[1] & cf[3], bg_offset_active_out)
    `CHK("chan_a", ea, chan_a_src_out)
    `CHK("chan_b", eb, chan_b_src_out)
    `CHK("idle_sel", il[1:0], core_idle_sel_out)
    `CHK("idle_en", !cf[1] && il[1:0] != 2'h3, core_idle_en_out)
    `CHK("core1_sub", !cf[1] && il[1:0] inside {2'h0, 2'h2}, core1_substitute_out)
    // Status: link off, route valid, applied swap and select, fg done, running
    rd(OFF_CALIBRATION_STATE_STAT, {1'b0, 1'b1, r[4], r[1:0], 1'b1, 2'h3}, "status");
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge sys_clk_in) serial_link_enable_in <= 1'b1;
  endtask

  initial begin
    repeat (9) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    `CHK("lin_avg_rst", RST_CALIBRATION_AVERAGING[2:0], lin_avg_out)
    `CHK("os_avg_rst", RST_CALIBRATION_AVERAGING[6:4], os_avg_out)
    `CHK("idle_sel_rst", RST_IDLE_CORE_CONFIG[1:0], core_idle_sel_out)
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(OFF_INPUT_ROUTE_SELECT, RST_INPUT_ROUTE_SELECT, "route_rst");
    rd(OFF_CALIBRATION_RUN_CTRL, RST_CALIBRATION_RUN_CTRL, "run_rst");
    rd(OFF_CALIBRATION_MODE_CFG, RST_CALIBRATION_MODE_CFG, "mode_rst");
    rd(OFF_IDLE_CORE_CONFIG, RST_IDLE_CORE_CONFIG, "idle_rst");
    rd(OFF_CALIBRATION_AVERAGING, RST_CALIBRATION_AVERAGING, "avg_rst");
    bus(1'b1, 1'b0, 8'h63, 8'hA5);
    rd(8'h63, 8'h00, "unmapped");
    // Reserved bits included: every bit must read back as written
    for (int i = 0; i < 20; i++) begin
      d = 8'($random(seed));
      bus(1'b1, 1'b0, offs[i % 5], d);
      rd(offs[i % 5], d, "readback");
    end
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    // Last pass wrote the averaging register; reserved bits 3 and 7 must not leak
    @(negedge sys_clk_in);
    `CHK("lin_avg", d[2:0], lin_avg_out)
    `CHK("os_avg", d[6:4], os_avg_out)
    for (int i = 0; i < 6; i++)
      rerun(rt[i][10], rt[i][9:2], 8'h01, 8'h02, rt[i][1], rt[i][0]);
    // New route without a rerun must leave the applied route alone
    bus(1'b1, 1'b0, OFF_INPUT_ROUTE_SELECT, 8'h12);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) @(negedge sys_clk_in);
    `CHK("chan_a_hold", 1'b0, chan_a_src_out)
    `CHK("chan_b_hold", 1'b1, chan_b_src_out)
    for (int i = 0; i < 16; i++)
      rerun(1'b0, 8'h01, 8'(i), 8'(i / 4), 1'b0, 1'b1);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    error_cnt++;
    print_verdict();
  end
endmodule
